// ==== design/eqc_pkg.sv ====
// Package with register map, field layout, reset values and states of the equalizer control.
package eqc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0C;
  // ----------------------------------------------------------------
  // Settings byte layout, shared by APB and the management bus
  // ----------------------------------------------------------------
  localparam int BOOST_LSB = 0;
  localparam int BOOST_W = 3;
  localparam int AMP_BIT = 3;
  localparam int SOFT_EN_BIT = 4;
  localparam int THR_LSB = 5;
  localparam int THR_W = 2;
  localparam logic [7:0] CTRL_RST = 8'h10;
  localparam logic [7:0] CTRL_WMASK = 8'h7F;
  // ----------------------------------------------------------------
  // Event bits of status and mask
  // ----------------------------------------------------------------
  localparam int EV_LOST = 0;
  localparam int EV_FOUND = 1;
  localparam int EV_SMB_WR = 2;
  localparam int EV_W = 3;
  // ----------------------------------------------------------------
  // Pin defaults that the pad pulls give an open pin, and bus bit counts
  // ----------------------------------------------------------------
  localparam logic [2:0] BOOST_PIN_RST = 3'h0;
  localparam logic FORCE_PIN_RST = 1'b1;
  localparam logic EN_PIN_RST = 1'b1;
  localparam logic BSEL_PIN_RST = 1'b0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_RD_BIT = 4'h7;
  // ----------------------------------------------------------------
  // Management bus slave states
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    SMB_IDLE = 7'h01,
    SMB_ADDR = 7'h02,
    SMB_AACK = 7'h04,
    SMB_WDATA = 7'h08,
    SMB_DACK = 7'h10,
    SMB_RDATA = 7'h20,
    SMB_RACK = 7'h40
  } eqc_smb_st_t;
endpackage : eqc_pkg

// ==== design/eqc_top.sv ====
// Digital control of a four-channel cable equalizer: boost source, standby, detect, buses.
// Contract
// - Eight boost levels, chosen by a three-bit code from pins or bus.
// - The three code bits together pick one boost for all channels.
// - Open boost pins read low, giving the lowest code.
// - Enable high runs normally while the bus soft enable bit is set; enable low puts the device in standby.
// - An open enable pin reads high, so the device runs.
// - One enable governs standby of all data and clock channels.
// - Force high takes the boost from the pins, ignoring bus value.
// - Force low takes the boost from the bus-programmed value.
// - An open force pin reads high, so pins select boost by default.
// - Signal-present output is high while the clock channel sees a signal and the device is not in standby.
// - Management register reachable only while bus select is high.
// - An open bus select pin reads low, disabling bus access.
// - The detect threshold is programmable over the management bus.
// - The bus controls boost, amplitude, enable and detect threshold.
module eqc_top #(
  parameter logic [6:0] SMB_ADDR = 7'h5A
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic boost_select_bit0,
  input wire logic boost_select_bit1,
  input wire logic boost_select_bit2,
  input wire logic external_boost_force,
  input wire logic enable_in,
  input wire logic bus_select,
  input wire logic bus_clock_in,
  input wire logic bus_data_in,
  output logic bus_data_out,
  output logic bus_data_oe,
  input wire logic clock_detect_raw,
  output logic clock_signal_present,
  output logic [2:0] applied_boost,
  output logic amplitude_sel,
  output logic [1:0] detect_threshold,
  output logic standby,
  output logic irq
);
  // Any slave address is allowed except zero, the general call address.
  if (SMB_ADDR == 7'h00) begin : g_bad_addr
    $error("eqc_top: address zero is the general call address");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] bst_m;
    logic [2:0] bst_s;
    logic frc_m;
    logic frc_s;
    logic en_m;
    logic en_s;
    logic bsel_m;
    logic bsel_s;
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic det_m;
    logic det_s;
    logic det_p;
    eqc_pkg::eqc_smb_st_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic [7:0] ctrl;
    logic [eqc_pkg::EV_W-1:0] status;
    logic [eqc_pkg::EV_W-1:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sda_oe;
    logic sda_out;
    logic present;
    logic [2:0] boost;
    logic amp;
    logic [1:0] thr;
    logic stby;
    logic irq;
  } eqc_state_t;

  eqc_state_t r_ff;
  eqc_state_t nxt_r;
  logic apb_acc;
  logic apb_wr;
  logic apb_rd;
  logic scl_rise;
  logic scl_fall;
  logic smb_start;
  logic smb_stop;
  logic smb_wr;
  logic [eqc_pkg::EV_W-1:0] ev;

  assign apb_acc = psel && penable && !r_ff.pready;
  assign apb_wr = psel && penable && r_ff.pready && pwrite;
  assign apb_rd = apb_acc && !pwrite;
  // Gating by the synced select keeps every bus edge away from an unselected slave.
  assign scl_rise = r_ff.bsel_s && r_ff.scl_s && !r_ff.scl_p;
  assign scl_fall = r_ff.bsel_s && !r_ff.scl_s && r_ff.scl_p;
  assign smb_start = r_ff.bsel_s && r_ff.scl_s && r_ff.scl_p && r_ff.sda_p && !r_ff.sda_s;
  assign smb_stop = r_ff.bsel_s && r_ff.scl_s && r_ff.scl_p && !r_ff.sda_p && r_ff.sda_s;
  assign smb_wr = scl_fall && (r_ff.st == eqc_pkg::SMB_WDATA) &&
                  (r_ff.cnt == eqc_pkg::BITS_PER_BYTE);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_r = r_ff;
    nxt_r.bst_m = {boost_select_bit2, boost_select_bit1, boost_select_bit0};
    nxt_r.bst_s = r_ff.bst_m;
    nxt_r.frc_m = external_boost_force;
    nxt_r.frc_s = r_ff.frc_m;
    nxt_r.en_m = enable_in;
    nxt_r.en_s = r_ff.en_m;
    nxt_r.bsel_m = bus_select;
    nxt_r.bsel_s = r_ff.bsel_m;
    nxt_r.scl_m = bus_clock_in;
    nxt_r.scl_s = r_ff.scl_m;
    nxt_r.scl_p = r_ff.scl_s;
    nxt_r.sda_m = bus_data_in;
    nxt_r.sda_s = r_ff.sda_m;
    nxt_r.sda_p = r_ff.sda_s;
    nxt_r.det_m = clock_detect_raw;
    nxt_r.det_s = r_ff.det_m;
    nxt_r.det_p = r_ff.present;

    // Management bus slave.
    if (!r_ff.bsel_s || smb_stop) begin
      nxt_r.st = eqc_pkg::SMB_IDLE;
      nxt_r.sda_oe = 1'b0;
    end else if (smb_start) begin
      nxt_r.st = eqc_pkg::SMB_ADDR;
      nxt_r.cnt = 4'h0;
      nxt_r.sda_oe = 1'b0;
    end else begin
      case (r_ff.st)
        eqc_pkg::SMB_ADDR, eqc_pkg::SMB_WDATA: begin
          if (scl_rise) begin
            nxt_r.sh = {r_ff.sh[6:0], r_ff.sda_s};
            nxt_r.cnt = r_ff.cnt + 4'h1;
          end else if (scl_fall && r_ff.cnt == eqc_pkg::BITS_PER_BYTE) begin
            nxt_r.cnt = 4'h0;
            if (r_ff.st == eqc_pkg::SMB_WDATA) begin
              nxt_r.st = eqc_pkg::SMB_DACK;
              nxt_r.sda_oe = 1'b1;
            end else if (r_ff.sh[7:1] == SMB_ADDR) begin
              nxt_r.st = eqc_pkg::SMB_AACK;
              nxt_r.rw = r_ff.sh[0];
              nxt_r.sda_oe = 1'b1;
            end else begin
              nxt_r.st = eqc_pkg::SMB_IDLE;
            end
          end
        end
        eqc_pkg::SMB_AACK: begin
          if (scl_fall) begin
            if (r_ff.rw) begin
              nxt_r.st = eqc_pkg::SMB_RDATA;
              nxt_r.sh = r_ff.ctrl;
              nxt_r.sda_oe = !r_ff.ctrl[7];
            end else begin
              nxt_r.st = eqc_pkg::SMB_WDATA;
              nxt_r.sda_oe = 1'b0;
            end
          end
        end
        eqc_pkg::SMB_DACK: begin
          if (scl_fall) begin
            nxt_r.st = eqc_pkg::SMB_WDATA;
            nxt_r.sda_oe = 1'b0;
          end
        end
        eqc_pkg::SMB_RDATA: begin
          if (scl_fall) begin
            if (r_ff.cnt == eqc_pkg::LAST_RD_BIT) begin
              nxt_r.st = eqc_pkg::SMB_RACK;
              nxt_r.cnt = 4'h0;
              nxt_r.sda_oe = 1'b0;
            end else begin
              nxt_r.sh = {r_ff.sh[6:0], 1'b0};
              nxt_r.cnt = r_ff.cnt + 4'h1;
              nxt_r.sda_oe = !r_ff.sh[6];
            end
          end
        end
        eqc_pkg::SMB_RACK: begin
          if (scl_rise && r_ff.sda_s) begin
            nxt_r.st = eqc_pkg::SMB_IDLE;
          end else if (scl_fall) begin
            nxt_r.st = eqc_pkg::SMB_RDATA;
            nxt_r.sh = r_ff.ctrl;
            nxt_r.sda_oe = !r_ff.ctrl[7];
          end
        end
        default: begin
          nxt_r.st = eqc_pkg::SMB_IDLE;
          nxt_r.sda_oe = 1'b0;
        end
      endcase
    end

    // Settings byte: APB wins over a management bus write in the same cycle.
    if (apb_wr && paddr == eqc_pkg::OFS_CTRL) begin
      nxt_r.ctrl = pwdata[7:0] & eqc_pkg::CTRL_WMASK;
    end else if (smb_wr) begin
      nxt_r.ctrl = r_ff.sh & eqc_pkg::CTRL_WMASK;
    end

    // Applied settings.
    nxt_r.boost = r_ff.frc_s ? r_ff.bst_s :
                  r_ff.ctrl[eqc_pkg::BOOST_LSB +: eqc_pkg::BOOST_W];
    nxt_r.amp = r_ff.ctrl[eqc_pkg::AMP_BIT];
    nxt_r.thr = r_ff.ctrl[eqc_pkg::THR_LSB +: eqc_pkg::THR_W];
    nxt_r.stby = !(r_ff.en_s && r_ff.ctrl[eqc_pkg::SOFT_EN_BIT]);
    nxt_r.present = r_ff.det_s && !r_ff.stby;

    // Sticky events; a new event wins over a write-one clear.
    if (apb_wr && paddr == eqc_pkg::OFS_STATUS) begin
      nxt_r.status = r_ff.status & ~pwdata[eqc_pkg::EV_W-1:0];
    end
    nxt_r.status = nxt_r.status | ev;
    if (apb_wr && paddr == eqc_pkg::OFS_MASK) begin
      nxt_r.mask = pwdata[eqc_pkg::EV_W-1:0];
    end
    nxt_r.irq = |(r_ff.status & r_ff.mask);

    // APB slave with one wait state.
    nxt_r.pready = apb_acc;
    nxt_r.pslverr = apb_acc && !(paddr == eqc_pkg::OFS_CTRL || paddr == eqc_pkg::OFS_STATUS ||
                                 paddr == eqc_pkg::OFS_MASK || paddr == eqc_pkg::OFS_STATE);
    nxt_r.prdata = 32'h0000_0000;
    if (apb_rd) begin
      case (paddr)
        eqc_pkg::OFS_CTRL: nxt_r.prdata = {24'h00_0000, r_ff.ctrl};
        eqc_pkg::OFS_STATUS: nxt_r.prdata = {29'h0, r_ff.status};
        eqc_pkg::OFS_MASK: nxt_r.prdata = {29'h0, r_ff.mask};
        eqc_pkg::OFS_STATE: nxt_r.prdata = {21'h00_0000, r_ff.bsel_s, r_ff.en_s, r_ff.frc_s,
                                            r_ff.bst_s, r_ff.stby, r_ff.present, r_ff.boost};
        default: nxt_r.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    ev = '0;
    ev[eqc_pkg::EV_LOST] = r_ff.det_p && !r_ff.present;
    ev[eqc_pkg::EV_FOUND] = !r_ff.det_p && r_ff.present;
    ev[eqc_pkg::EV_SMB_WR] = smb_wr;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff <= '0;
      r_ff.bst_m <= eqc_pkg::BOOST_PIN_RST;
      r_ff.bst_s <= eqc_pkg::BOOST_PIN_RST;
      r_ff.frc_m <= eqc_pkg::FORCE_PIN_RST;
      r_ff.frc_s <= eqc_pkg::FORCE_PIN_RST;
      r_ff.en_m <= eqc_pkg::EN_PIN_RST;
      r_ff.en_s <= eqc_pkg::EN_PIN_RST;
      r_ff.bsel_m <= eqc_pkg::BSEL_PIN_RST;
      r_ff.bsel_s <= eqc_pkg::BSEL_PIN_RST;
      r_ff.scl_m <= 1'b1;
      r_ff.scl_s <= 1'b1;
      r_ff.scl_p <= 1'b1;
      r_ff.sda_m <= 1'b1;
      r_ff.sda_s <= 1'b1;
      r_ff.sda_p <= 1'b1;
      r_ff.st <= eqc_pkg::SMB_IDLE;
      r_ff.ctrl <= eqc_pkg::CTRL_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign prdata = r_ff.prdata;
  assign pready = r_ff.pready;
  assign pslverr = r_ff.pslverr;
  assign bus_data_out = r_ff.sda_out;
  assign bus_data_oe = r_ff.sda_oe;
  assign clock_signal_present = r_ff.present;
  assign applied_boost = r_ff.boost;
  assign amplitude_sel = r_ff.amp;
  assign detect_threshold = r_ff.thr;
  assign standby = r_ff.stby;
  assign irq = r_ff.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_FORCE_PINS: assert property (r_ff.frc_s |=> applied_boost == $past(r_ff.bst_s))
    else $error("boost not taken from pins while forced");
  AST_FORCE_BUS: assert property (
    !r_ff.frc_s |=> applied_boost == $past(r_ff.ctrl[eqc_pkg::BOOST_LSB +: eqc_pkg::BOOST_W]))
    else $error("boost not taken from bus value");
  AST_STANDBY: assert property (!r_ff.en_s |=> standby ##1 !clock_signal_present)
    else $error("enable low did not reach standby");
  AST_RUN: assert property (r_ff.en_s && r_ff.ctrl[eqc_pkg::SOFT_EN_BIT] |=> !standby)
    else $error("standby while enabled");
  AST_PRESENT: assert property (r_ff.det_s && !standby |=> clock_signal_present)
    else $error("signal present not shown");
  AST_NO_DRIVE: assert property (!r_ff.bsel_s |=> !bus_data_oe)
    else $error("bus data driven while unselected");
  AST_HOLD: assert property (
    !r_ff.bsel_s && !(apb_wr && paddr == eqc_pkg::OFS_CTRL) |=> $stable(r_ff.ctrl))
    else $error("settings changed while unselected");
  AST_THR: assert property (
    $changed(r_ff.ctrl[eqc_pkg::THR_LSB +: eqc_pkg::THR_W]) |=>
    detect_threshold == $past(r_ff.ctrl[eqc_pkg::THR_LSB +: eqc_pkg::THR_W]))
    else $error("threshold not applied");
  AST_IRQ: assert property (|(r_ff.status & r_ff.mask) |=> irq)
    else $error("interrupt missing");
  AST_READY: assert property (apb_acc |=> pready ##1 !pready)
    else $error("apb answer wrong");
  COV_SMB_WR: cover property (smb_wr);
  COV_SMB_RD: cover property (r_ff.st == eqc_pkg::SMB_RACK);
  COV_LOST: cover property (ev[eqc_pkg::EV_LOST] ##1 irq);
endmodule : eqc_top

// ==== dv/eqc_smb_host.sv ====
// Behavioural management bus host that frames transfers at a 160 ns bit period.
module eqc_smb_host (
  output logic clk_out,
  output logic dat_low,
  input wire logic dat
);
  timeunit 1ns;
  timeprecision 100ps;
  // The clock rests high between frames and the data line is only ever pulled low.
  initial begin
    clk_out = 1'b1;
    dat_low = 1'b0;
  end
  // The small offset keeps every bus edge clear of the sampling clock edge.
  task automatic frame_start();
    #3;
    dat_low = 1'b0;
    clk_out = 1'b1;
    #80 dat_low = 1'b1;
    #80 clk_out = 1'b0;
    #40;
  endtask : frame_start
  task automatic bit_out(input logic b);
    #20 dat_low = ~b;
    #20 clk_out = 1'b1;
    #80 clk_out = 1'b0;
    #40;
  endtask : bit_out
  task automatic bit_in(output logic b);
    #20 dat_low = 1'b0;
    #20 clk_out = 1'b1;
    #40 b = dat;
    #40 clk_out = 1'b0;
    #40;
  endtask : bit_in
  task automatic put_byte(input logic [7:0] v, output logic nack);
    for (int i = 7; i >= 0; i--) begin
      bit_out(v[i]);
    end
    bit_in(nack);
  endtask : put_byte
  task automatic get_byte(output logic [7:0] v, input logic last);
    for (int i = 7; i >= 0; i--) begin
      bit_in(v[i]);
    end
    bit_out(last);
  endtask : get_byte
  task automatic frame_stop();
    #20 dat_low = 1'b1;
    #20 clk_out = 1'b1;
    #80 dat_low = 1'b0;
    #80;
  endtask : frame_stop
endmodule : eqc_smb_host

// ==== dv/tb_top.sv ====
// Self-checking bench of the equalizer control block.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err, nack;
  logic [7:0] paddr, v;
  logic [31:0] pwdata, prdata, r;
  logic [2:0] pins, boost;
  logic [1:0] thr;
  logic force_pin, enable_in, bus_select, detect_raw, host_clk, host_low;
  logic dat_out, dat_oe, present, amp, standby, irq;
  wire smb_dat;
  int err_total, total_checks, oe_cnt, n;
  // The data line has a pull-up, so it is high unless someone pulls it low.
  assign smb_dat = ~(host_low | dat_oe);
  eqc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .boost_select_bit0(pins[0]), .boost_select_bit1(pins[1]),
    .boost_select_bit2(pins[2]), .external_boost_force(force_pin), .enable_in(enable_in),
    .bus_select(bus_select), .bus_clock_in(host_clk), .bus_data_in(smb_dat),
    .bus_data_out(dat_out), .bus_data_oe(dat_oe), .clock_detect_raw(detect_raw),
    .clock_signal_present(present), .applied_boost(boost), .amplitude_sel(amp),
    .detect_threshold(thr), .standby(standby), .irq(irq));
  eqc_smb_host HOST (.clk_out(host_clk), .dat_low(host_low), .dat(smb_dat));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (dat_oe === 1'b1) begin
      oe_cnt++;
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      wrap_up();
    end
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd
  task automatic settle();
    repeat (8) @(posedge pclk);
  endtask : settle
  task automatic wait_irq(input logic lvl);
    n = 0;
    while (irq !== lvl && n < 50) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(irq), 32'(lvl));
    if (irq !== lvl) wrap_up();
  endtask : wait_irq
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_pins();
    rd(eqc_pkg::OFS_STATE, 32'h300);
    rd(eqc_pkg::OFS_CTRL, 32'(eqc_pkg::CTRL_RST));
    apb(1'b1, eqc_pkg::OFS_CTRL, 32'h17);
    for (int k = 0; k < 8; k++) begin
      pins <= 3'(k);
      settle();
      chk(32'(boost), 32'(k));
    end
    $display("test pins done");
  endtask : t_pins
  task automatic t_bus();
    force_pin <= 1'b0;
    pins <= 3'h5;
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, eqc_pkg::OFS_CTRL, {24'h0, 1'b0, 2'(k), 1'b1, k[0], 3'(k)});
      settle();
      chk({amp, thr, boost}, {k[0], 2'(k), 3'(k)});
    end
    $display("test bus done");
  endtask : t_bus
  task automatic t_standby();
    detect_raw <= 1'b1;
    settle();
    chk({standby, present}, 2'b01);
    enable_in <= 1'b0;
    settle();
    chk({standby, present}, 2'b10);
    enable_in <= 1'b1;
    apb(1'b1, eqc_pkg::OFS_CTRL, 32'h00);
    settle();
    chk({standby, present}, 2'b10);
    apb(1'b1, eqc_pkg::OFS_CTRL, 32'h10);
    settle();
    chk({standby, present}, 2'b01);
    detect_raw <= 1'b0;
    settle();
    chk({standby, present}, 2'b00);
    $display("test standby done");
  endtask : t_standby
  task automatic t_irq();
    apb(1'b1, eqc_pkg::OFS_STATUS, 32'h7);
    apb(1'b1, eqc_pkg::OFS_MASK, 32'h3);
    wait_irq(1'b0);
    detect_raw <= 1'b1;
    wait_irq(1'b1);
    rd(eqc_pkg::OFS_STATUS, 32'h2);
    apb(1'b1, eqc_pkg::OFS_STATUS, 32'h2);
    wait_irq(1'b0);
    apb(1'b1, eqc_pkg::OFS_MASK, 32'h0);
    detect_raw <= 1'b0;
    settle();
    chk(32'(irq), 32'h0);
    rd(eqc_pkg::OFS_STATUS, 32'h1);
    apb(1'b1, eqc_pkg::OFS_STATUS, 32'h7);
    rd(8'h10, 32'h0);
    chk(32'(last_err), 32'h1);
    $display("test irq done");
  endtask : t_irq
  task automatic t_smb();
    bus_select <= 1'b1;
    settle();
    HOST.frame_start();
    HOST.put_byte({7'h5A, 1'b0}, nack);
    chk(32'(nack), 32'h0);
    HOST.put_byte(8'h6B, nack);
    chk(32'(nack), 32'h0);
    HOST.frame_stop();
    settle();
    chk({thr, amp, standby, boost}, {2'h3, 1'b1, 1'b1, 3'h3});
    rd(eqc_pkg::OFS_STATUS, 32'h4);
    HOST.frame_start();
    HOST.put_byte({7'h5A, 1'b1}, nack);
    chk(32'(nack), 32'h0);
    HOST.get_byte(v, 1'b1);
    HOST.frame_stop();
    chk(32'(v), 32'h6B);
    chk(32'(dat_out), 32'h0);
    settle();
    $display("test smb done");
  endtask : t_smb
  task automatic t_blocked();
    int base;
    bus_select <= 1'b0;
    settle();
    base = oe_cnt;
    HOST.frame_start();
    HOST.put_byte({7'h5A, 1'b0}, nack);
    chk(32'(nack), 32'h1);
    HOST.put_byte(8'h15, nack);
    HOST.frame_stop();
    settle();
    chk(32'(oe_cnt - base), 32'h0);
    rd(eqc_pkg::OFS_CTRL, 32'h6B);
    $display("test blocked done");
  endtask : t_blocked
  initial begin
    #900000;
    err_total++;
    wrap_up();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pins, detect_raw, bus_select} = '0;
    force_pin = 1'b1;
    enable_in = 1'b1;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_pins();
    t_bus();
    t_standby();
    t_irq();
    t_smb();
    t_blocked();
    wrap_up();
  end
endmodule : tb_top
